//--- hdl/rrs_pkg.sv
// Shared constants, register map and enumerations of the return/rotate/subtract unit
`default_nettype none
package rrs_pkg;
  // ============================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int PC_W = 15;
  localparam int FADDR_W = 7;
  localparam int MEM_WORDS = 128;
  localparam int STK_DEPTH = 16;
  localparam int DEPTH_W = 5;
  localparam int ADDR_W = 8;
  localparam int OP_W = 3;
  // ============================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ACC = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PC = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PUSH = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MADDR = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MDATA = 8'h18;
  // ============================================================
  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_FADDR_LSB = 4;
  localparam int CMD_LIT_LSB = 16;
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_DEPTH_LSB = 16;
  localparam int ERR_BIT = 32;
  // ============================================================
  // Enumerations
  typedef enum logic [OP_W-1:0] {
    op_none, op_ret, op_ret_lit, op_rotl, op_rotr, op_lit_sub
  } rrs_op_e;
  localparam logic [OP_W-1:0] OP_LAST = 3'h5;
  typedef enum logic [1:0] {st_idle, st_exec, st_ret1, st_ret2} rrs_state_e;
endpackage
`default_nettype wire

//--- hdl/rrs_ex_if.sv
// Carrier between the core, its arithmetic unit and its return stack
`default_nettype none
interface rrs_ex_if import rrs_pkg::*; ();
  rrs_op_e op;
  logic [DATA_W-1:0] src;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] acc;
  logic cin;
  logic [DATA_W-1:0] res;
  logic cout;
  logic dcout;
  logic zout;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_val;
  logic [PC_W-1:0] top;
  logic [DEPTH_W-1:0] depth;
  modport alu(input op, src, lit, acc, cin, output res, cout, dcout, zout);
  modport stk(input push, pop, push_val, output top, depth);
  modport core(output op, src, lit, acc, cin, push, pop, push_val,
               input res, cout, dcout, zout, top, depth);
endinterface
`default_nettype wire

//--- hdl/rrs_alu.sv
// Combinational rotate and literal-subtract unit
`default_nettype none
module rrs_alu import rrs_pkg::*; (
  rrs_ex_if.alu ex
);
  logic [DATA_W:0] diff;

  // ============================================================
  // Result and flag generation
  always_comb begin
    diff = {1'b0, ex.lit} + {1'b0, ~ex.acc} + {{DATA_W{1'b0}}, 1'b1};
    ex.res = ex.acc;
    ex.cout = ex.cin;
    ex.dcout = 1'b0;
    unique case (ex.op)
      op_rotl: begin
        ex.res = {ex.src[DATA_W-2:0], ex.cin}; // RULE4
        ex.cout = ex.src[DATA_W-1]; // RULE4
      end
      op_rotr: begin
        ex.res = {ex.cin, ex.src[DATA_W-1:1]}; // RULE6
        ex.cout = ex.src[0]; // RULE6
      end
      op_lit_sub: begin
        ex.res = diff[DATA_W-1:0]; // RULE7
        ex.cout = diff[DATA_W]; // RULE8
        ex.dcout = ex.acc[NIB_W-1:0] <= ex.lit[NIB_W-1:0]; // RULE8
      end
      op_none, op_ret, op_ret_lit: begin
        ex.res = ex.acc;
      end
    endcase
    ex.zout = (ex.res == '0); // RULE9
  end
endmodule // rrs_alu
`default_nettype wire

//--- hdl/rrs_stack.sv
// Return-address stack; overflow silently drops the oldest entry
`default_nettype none
module rrs_stack import rrs_pkg::*; #(
  parameter int DEPTH = STK_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  rrs_ex_if.stk ex
);
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] ent;
    logic [DEPTH_W-1:0] cnt;
  } rrs_stk_s;
  rrs_stk_s q;
  rrs_stk_s d;

  // ============================================================
  // Shift stack: entry 0 is always the top
  always_comb begin
    d = q;
    if (ex.pop) begin
      d.ent = {{PC_W{1'b0}}, q.ent[DEPTH-1:1]};
      if (q.cnt != '0) d.cnt = q.cnt - DEPTH_W'(1);
    end else if (ex.push) begin
      d.ent = {q.ent[DEPTH-2:0], ex.push_val};
      if (q.cnt != DEPTH_W'(DEPTH)) d.cnt = q.cnt + DEPTH_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ex.top = q.ent[0];
  assign ex.depth = q.cnt;
endmodule // rrs_stack
`default_nettype wire

//--- hdl/rrs_core.sv
// APB-controlled executor for return, rotate and literal-subtract instructions
//
// Contract
// RULE1 - Plain return pops the stack into the program counter; two cycles, flags kept.
// RULE2 - Literal return loads its 8-bit literal into the accumulator.
// RULE3 - Literal return also pops stack into program counter; two cycles, flags kept.
// RULE4 - Rotate left: bits move up, carry enters bit 0, bit 7 becomes carry.
// RULE5 - Rotate target zero writes accumulator; target one writes back the source.
// RULE6 - Rotate right: bits move down, carry enters bit 7, bit 0 becomes carry.
// RULE7 - Literal minus accumulator, two's complement, result into accumulator.
// RULE8 - Carry set when accumulator not above literal; digit carry likewise on nibbles.
// RULE9 - Zero flag set exactly when the subtraction result is zero.
//
// Our own choices: the APB slave port and the register addresses.
`default_nettype none
module rrs_core import rrs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  typedef struct packed {
    rrs_state_e st;
    rrs_op_e op;
    logic dest;
    logic [FADDR_W-1:0] fa;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] acc;
    logic c;
    logic dc;
    logic z;
    logic [PC_W-1:0] pc;
    logic [FADDR_W-1:0] maddr;
    logic [MEM_WORDS-1:0][DATA_W-1:0] mem;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
  } rrs_core_s;

  rrs_core_s q;
  rrs_core_s d;
  rrs_ex_if exi();

  // ============================================================
  // Register read decode; top bit flags a mapped address
  function automatic logic [32:0] reg_read(input rrs_core_s s,
                                           input logic [ADDR_W-1:0] a,
                                           input logic [DEPTH_W-1:0] dep);
    logic [32:0] r;
    r = '0;
    r[ERR_BIT] = 1'b1;
    case (a)
      REG_CMD, REG_PUSH: r[ERR_BIT] = 1'b1;
      REG_ACC: r[DATA_W-1:0] = s.acc;
      REG_STATUS: begin
        r[ST_C_BIT] = s.c;
        r[ST_DC_BIT] = s.dc;
        r[ST_Z_BIT] = s.z;
        r[ST_BUSY_BIT] = (s.st != st_idle);
        r[ST_DEPTH_LSB +: DEPTH_W] = dep;
      end
      REG_PC: r[PC_W-1:0] = s.pc;
      REG_MADDR: r[FADDR_W-1:0] = s.maddr;
      REG_MDATA: r[DATA_W-1:0] = s.mem[s.maddr];
      default: r[ERR_BIT] = 1'b0;
    endcase
    return r;
  endfunction

  // Byte-lane merge so partial writes keep the untouched lanes, except REG_CMD and REG_PUSH, which read as zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    end
    return m;
  endfunction

  // ============================================================
  // Bus phase decode
  logic acc_phase;
  logic decide;
  logic we;
  logic [32:0] rd;
  logic [31:0] wv;
  logic bad_op;

  assign acc_phase = psel & penable;
  assign decide = acc_phase & ~q.pready;
  // A write lands only at the edge where the master sees pready
  assign we = acc_phase & q.pready & pwrite & ~q.pslverr;
  assign rd = reg_read(q, paddr, exi.depth);
  assign wv = merge(rd[31:0], pwdata, pstrb);
  assign bad_op = (paddr == REG_CMD) && (wv[CMD_OP_LSB +: OP_W] > OP_LAST);

  // ============================================================
  // Links to the arithmetic unit and the stack
  assign exi.op = q.op;
  assign exi.src = q.mem[q.fa];
  assign exi.lit = q.lit;
  assign exi.acc = q.acc;
  assign exi.cin = q.c;
  assign exi.push = we && (paddr == REG_PUSH);
  assign exi.push_val = wv[PC_W-1:0];
  assign exi.pop = (q.st == st_ret1); // RULE1 RULE3

  rrs_alu u_alu (
    .ex(exi)
  );

  rrs_stack #(
    .DEPTH(STK_DEPTH)
  ) u_stack (
    .clk(pclk),
    .rstn(presetn),
    .ex(exi)
  );

  // ============================================================
  // Next-state logic: bus slave then instruction sequencer
  always_comb begin
    d = q;
    d.pready = decide;
    // One wait state buys a registered read path and error answer
    if (decide) begin
      d.prdata = pwrite ? '0 : rd[31:0];
      d.pslverr = ~rd[ERR_BIT] | (pwrite & ((q.st != st_idle) | bad_op));
    end else begin
      d.pslverr = 1'b0; // Error answer never outlives its pready pulse
    end
    // Writes are refused while busy, so they never race the sequencer
    if (we) begin
      case (paddr)
        REG_CMD: begin
          d.op = rrs_op_e'(wv[CMD_OP_LSB +: OP_W]);
          d.dest = wv[CMD_DEST_BIT];
          d.fa = wv[CMD_FADDR_LSB +: FADDR_W];
          d.lit = wv[CMD_LIT_LSB +: DATA_W];
          if (d.op == op_ret || d.op == op_ret_lit) begin
            d.st = st_ret1;
          end else if (d.op != op_none) begin
            d.st = st_exec;
          end
        end
        REG_ACC: d.acc = wv[DATA_W-1:0];
        REG_STATUS: begin
          d.c = wv[ST_C_BIT];
          d.dc = wv[ST_DC_BIT];
          d.z = wv[ST_Z_BIT];
        end
        REG_PC: d.pc = wv[PC_W-1:0];
        REG_MADDR: d.maddr = wv[FADDR_W-1:0];
        REG_MDATA: d.mem[q.maddr] = wv[DATA_W-1:0];
        default: d.pc = q.pc;
      endcase
    end
    unique case (q.st)
      st_idle: d.busy = d.busy;
      st_exec: begin
        d.st = st_idle;
        if (q.op == op_lit_sub) begin
          d.acc = exi.res; // RULE7
          d.c = exi.cout; // RULE8
          d.dc = exi.dcout; // RULE8
          d.z = exi.zout; // RULE9
        end else begin
          d.c = exi.cout; // RULE4 RULE6
          if (q.dest) begin
            d.mem[q.fa] = exi.res; // RULE5
          end else begin
            d.acc = exi.res; // RULE5
          end
        end
      end
      st_ret1: begin
        d.pc = exi.top; // RULE1 RULE3
        if (q.op == op_ret_lit) d.acc = q.lit; // RULE2
        d.st = st_ret2; // RULE1 RULE3
      end
      st_ret2: d.st = st_idle;
    endcase
    d.busy = (d.st != st_idle);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign busy = q.busy;

  // ============================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic is_exec;
  logic is_rot;
  assign is_exec = (q.st == st_exec);
  assign is_rot = (q.op == op_rotl) || (q.op == op_rotr);

  property p_ret_pc;
    q.st == st_ret1 |=> q.pc == $past(exi.top);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return did not load pc"); // RULE1

  property p_ret_flags;
    q.st == st_ret1 |=> ($stable({q.c, q.dc, q.z}))[*2];
  endproperty
  a_ret_flags: assert property (p_ret_flags) else $error("return changed flags"); // RULE1

  property p_ret_lit;
    (q.st == st_ret1 && q.op == op_ret_lit) |=> q.acc == $past(q.lit);
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("literal not in accumulator"); // RULE2

  property p_ret_len;
    q.st == st_ret1 |=> q.st == st_ret2 ##1 q.st == st_idle;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return not two cycles"); // RULE3

  property p_ret_pop;
    (q.st == st_ret1 && exi.depth != '0) |=> exi.depth == $past(exi.depth) - 1'b1;
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not pop"); // RULE3

  property p_rotl;
    (is_exec && q.op == op_rotl) |=> q.c == $past(exi.src[DATA_W-1])
      && (q.dest ? q.mem[q.fa] : q.acc) == $past({exi.src[DATA_W-2:0], q.c})
      && $stable({q.dc, q.z});
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left wrong"); // RULE4

  property p_rot_keep;
    (is_exec && is_rot && !q.dest) |=> $stable(q.mem[q.fa]);
  endproperty
  a_rot_keep: assert property (p_rot_keep) else $error("rotate source clobbered"); // RULE5

  property p_rot_back;
    (is_exec && is_rot && q.dest) |=> $stable(q.acc);
  endproperty
  a_rot_back: assert property (p_rot_back) else $error("rotate touched acc"); // RULE5

  property p_rotr;
    (is_exec && q.op == op_rotr) |=> q.c == $past(exi.src[0])
      && (q.dest ? q.mem[q.fa] : q.acc) == $past({q.c, exi.src[DATA_W-1:1]})
      && $stable({q.dc, q.z});
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right wrong"); // RULE6

  property p_sub_val;
    (is_exec && q.op == op_lit_sub) |=> q.acc == $past(DATA_W'(q.lit - q.acc));
  endproperty
  a_sub_val: assert property (p_sub_val) else $error("subtract result wrong"); // RULE7

  property p_sub_flags;
    (is_exec && q.op == op_lit_sub) |=> q.c == $past(q.acc <= q.lit)
      && q.dc == $past(q.acc[NIB_W-1:0] <= q.lit[NIB_W-1:0]);
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract carries wrong"); // RULE8

  property p_sub_z;
    (is_exec && q.op == op_lit_sub) |=> q.z == ($past(q.lit) == $past(q.acc));
  endproperty
  a_sub_z: assert property (p_sub_z) else $error("zero flag wrong"); // RULE9

  // ============================================================
  // Bus answer checks: pready is a one-cycle pulse and the error flag only ever rides with it
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than a cycle");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  // Main scenarios
  c_ret_lit: cover property (q.st == st_ret1 && q.op == op_ret_lit);
  c_ret_plain: cover property (q.st == st_ret1 && q.op == op_ret);
  c_rot_back: cover property (is_exec && is_rot && q.dest);
  c_sub_zero: cover property (is_exec && q.op == op_lit_sub && exi.zout);
  c_sub_borrow: cover property (is_exec && q.op == op_lit_sub && !exi.cout);
endmodule // rrs_core
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench of the return, rotate and literal-subtract unit
`default_nettype none
module tb import rrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, busy;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  // ==========================================
  // Clock, device and hang guard
  always #2 pclk = ~pclk;
  rrs_core rrs_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));
  // Well above the few hundred cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     input logic [3:0] strb, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic eerr,
                    input logic [3:0] strb = 4'hf);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, strb, r, e);
    chk({31'h0, e}, {31'h0, eerr});
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                       input logic eerr = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk({31'h0, e}, {31'h0, eerr});
    if (!eerr) chk(r, exp);
  endtask
  function automatic logic [31:0] stw(input logic c, input logic dc, input logic z,
                                      input logic [4:0] dep);
    return {11'h0, dep, 7'h0, 1'b0, 5'h0, z, dc, c};
  endfunction
  // Busy must stand exactly ncyc cycles after the command lands
  task automatic exec(input rrs_op_e op, input logic dest, input logic [6:0] fa,
                      input logic [7:0] lit, input int ncyc);
    wr(REG_CMD, {8'h0, lit, 5'h0, fa, dest, op}, 1'b0);
    for (int i = 0; i < ncyc; i++) begin
      @(negedge pclk);
      chk({31'h0, busy}, 32'h1);
    end
    @(negedge pclk);
    chk({31'h0, busy}, 32'h0);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rdchk(REG_ACC, 32'h0);
    rdchk(REG_STATUS, 32'h0);
    rdchk(REG_PC, 32'h0);
    rdchk(8'h1c, 32'h0, 1'b1);
    rdchk(8'h05, 32'h0, 1'b1);
    wr(REG_CMD, 32'h0000_0006, 1'b1);
    exec(op_none, 1'b0, 7'h00, 8'h00, 0);
    wr(REG_ACC, 32'h0000_0077, 1'b0);
    wr(REG_ACC, 32'h0000_0011, 1'b0, 4'h0);
    rdchk(REG_ACC, 32'h0000_0077);
  endtask
  task automatic t_rotate();
    logic [6:0] fa [4] = '{7'h00, 7'h7f, 7'h05, 7'h40};
    logic [7:0] v [4] = '{8'he6, 8'h81, 8'h01, 8'h80};
    logic [7:0] res;
    logic cin, cout, dest, right;
    for (int i = 0; i < 4; i++) begin
      right = i[0];
      dest = i[1];
      cin = i[0] ^ i[1];
      res = right ? {cin, v[i][7:1]} : {v[i][6:0], cin};
      cout = right ? v[i][0] : v[i][7];
      wr(REG_MADDR, {25'h0, fa[i]}, 1'b0);
      wr(REG_MDATA, {24'h0, v[i]}, 1'b0);
      wr(REG_STATUS, stw(cin, 1'b1, 1'b1, 5'h0), 1'b0);
      wr(REG_ACC, 32'h0000_003c, 1'b0);
      exec(right ? op_rotr : op_rotl, dest, fa[i], 8'h5a, 1);
      rdchk(REG_ACC, {24'h0, dest ? 8'h3c : res});
      rdchk(REG_MDATA, {24'h0, dest ? res : v[i]});
      rdchk(REG_STATUS, stw(cout, 1'b1, 1'b1, 5'h0));
    end
  endtask
  task automatic t_sub();
    logic [7:0] a [6] = '{8'h05, 8'h06, 8'h10, 8'h01, 8'hff, 8'h00};
    logic [7:0] k [6] = '{8'h05, 8'h05, 8'h0f, 8'h10, 8'h00, 8'hff};
    logic [7:0] res;
    for (int i = 0; i < 6; i++) begin
      res = k[i] - a[i];
      wr(REG_ACC, {24'h0, a[i]}, 1'b0);
      exec(op_lit_sub, 1'b0, 7'h00, k[i], 1);
      rdchk(REG_ACC, {24'h0, res});
      rdchk(REG_STATUS, stw(a[i] <= k[i], a[i][3:0] <= k[i][3:0], res == 8'h0,
                            5'h0));
    end
  endtask
  task automatic t_return();
    wr(REG_STATUS, stw(1'b1, 1'b0, 1'b1, 5'h0), 1'b0);
    wr(REG_PUSH, 32'h0000_1234, 1'b0);
    wr(REG_PUSH, 32'h0000_7fff, 1'b0);
    rdchk(REG_STATUS, stw(1'b1, 1'b0, 1'b1, 5'h2));
    exec(op_ret_lit, 1'b0, 7'h00, 8'hff, 2);
    rdchk(REG_ACC, 32'h0000_00ff);
    rdchk(REG_PC, 32'h0000_7fff);
    rdchk(REG_STATUS, stw(1'b1, 1'b0, 1'b1, 5'h1));
    exec(op_ret, 1'b0, 7'h00, 8'h00, 2);
    rdchk(REG_PC, 32'h0000_1234);
    rdchk(REG_ACC, 32'h0000_00ff);
    rdchk(REG_STATUS, stw(1'b1, 1'b0, 1'b1, 5'h0));
    wr(REG_PUSH, 32'h0000_0001, 1'b0);
    exec(op_ret_lit, 1'b0, 7'h00, 8'h00, 2);
    rdchk(REG_ACC, 32'h0000_0000);
    rdchk(REG_PC, 32'h0000_0001);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rotate();
    t_sub();
    t_return();
    stop_test();
  end
endmodule // tb
`default_nettype wire
